// file: design/dsu_pkg.sv
// package for the debug serial port: register map, status layout, frame constants
// assumes a 16-bit processor data bus with 16-bit word addresses
package dsu_pkg;
  localparam logic [15:0] ADDR_LINE_STATUS = 16'hC028;
  localparam logic [15:0] ADDR_DATA_LOW = 16'hC029;
  localparam logic [15:0] ADDR_DATA_HIGH = 16'hC02A;
  localparam logic [15:0] ADDR_BAUD_DIVIDER = 16'hC02B;
  localparam logic [15:0] BAUD_DIVIDER_RESET = 16'h0000;
  localparam int ST_SHIFTER_ACTIVE = 0;
  localparam int ST_TX_FULL = 1;
  localparam int ST_RX_FULL = 2;
  localparam int ST_RX_OVERRUN = 3;
  localparam int ST_FRAME_ERR = 4;
  localparam int DIV_PRESCALE_LSB = 8;
  localparam int DATA_BITS = 8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  typedef struct packed {
    logic frame_err;
    logic overrun;
    logic rx_full;
    logic tx_full;
    logic shifter_active;
  } dsu_status_t;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} dsu_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} dsu_rx_state_t;
endpackage

// file: design/dsu_uart.sv
// debug serial port: transmit and receive holding registers, shifters, baud divider
// assumes a one-cycle bus strobe on REF_CLK; RXD arrives asynchronously
`timescale 1ns/1ps
// How it works
// - transmit line idles high between frames
// - start low, eight data lsb first, stop high
// - zero stop bit sets framing error flag
// - overrun loads previous receive-full on transfer
// - receive-full set on transfer, cleared by read
// - transmit-full high while holding register occupied
// - shifter-active high while frame is sent
// - low data read returns byte low, upper zero
// - receive interrupt on each holding transfer
// - data write queues only the addressed byte lane
// - idle write loads shifter, interrupts, starts
// - busy write holds byte until frame ends
// - upper data register mirrors low, bits 15:8
// - divider resets zero, prescale high byte
// - bit rate is clock over (d1+1)*d2
// - holding empties when its frame begins
// - falling edge while idle starts a frame
// - data sampled mid-bit by fixed timer
// - frame end transfers, checks, interrupts, idles
// - sample tick is the prescale divider output
module dsu_uart
  import dsu_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [15:0] BUS_ADDR,
  input wire logic BUS_RD,
  input wire logic BUS_WR,
  input wire logic [15:0] BUS_WDATA,
  output logic [15:0] BUS_RDATA,
  input wire logic RXD,
  output logic TXD,
  output logic TRANSMIT_INTERRUPT_PULSE,
  output logic RECEIVE_INTERRUPT_PULSE
);
  // bus decode
  wire sel_status = BUS_ADDR == ADDR_LINE_STATUS;
  wire sel_low = BUS_ADDR == ADDR_DATA_LOW;
  wire sel_high = BUS_ADDR == ADDR_DATA_HIGH;
  wire sel_div = BUS_ADDR == ADDR_BAUD_DIVIDER;
  wire data_wr = BUS_WR && (sel_low || sel_high);
  wire data_rd = BUS_RD && (sel_low || sel_high);
  // only the addressed byte lane is queued
  wire [7:0] wr_byte = sel_high ? BUS_WDATA[15:8] : BUS_WDATA[7:0];

  logic [15:0] div_r;
  wire [7:0] prescale_divider = div_r[15:DIV_PRESCALE_LSB];
  wire [7:0] bit_time_divider = div_r[7:0];

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      div_r <= BAUD_DIVIDER_RESET;
    else if (BUS_WR && sel_div)
      div_r <= BUS_WDATA;
  end

  // first divider: one tick every d1+1 clocks
  logic [7:0] pre_cnt_r;
  wire pre_tick = pre_cnt_r >= prescale_divider;
  always_ff @(posedge REF_CLK)
  begin
    if (RESET || pre_tick)
      pre_cnt_r <= BYTE_ZERO;
    else
      pre_cnt_r <= pre_cnt_r + BYTE_ONE;
  end

  // receive line synchroniser
  logic rxd_meta_r;
  logic rxd_sync_r;
  logic rxd_prev_r;
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      rxd_meta_r <= 1'b1;
      rxd_sync_r <= 1'b1;
      rxd_prev_r <= 1'b1;
    end
    else
    begin
      rxd_meta_r <= RXD;
      rxd_sync_r <= rxd_meta_r;
      rxd_prev_r <= rxd_sync_r;
    end
  end

  // two-entry buffer between bus writes and the shifter
  logic [7:0] buf_data_r [2];
  logic buf_wp_r;
  logic buf_rp_r;
  logic [1:0] buf_cnt_r;
  wire buf_in_valid = data_wr;
  wire buf_in_ready = buf_cnt_r != 2'h2;
  wire buf_out_valid = buf_cnt_r != 2'h0;
  logic buf_out_ready;
  wire buf_push = buf_in_valid && buf_in_ready;
  wire buf_pop = buf_out_valid && buf_out_ready;
  wire [7:0] buf_out_data = buf_data_r[buf_rp_r];

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      buf_wp_r <= 1'b0;
      buf_rp_r <= 1'b0;
      buf_cnt_r <= 2'h0;
    end
    else
    begin
      if (buf_push)
        buf_wp_r <= ~buf_wp_r;
      if (buf_pop)
        buf_rp_r <= ~buf_rp_r;
      buf_cnt_r <= buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (buf_push)
      buf_data_r[buf_wp_r] <= wr_byte;
  end

  // transmitter
  dsu_tx_state_t tx_state_r;
  dsu_tx_state_t tx_state_nxt;
  logic [7:0] tx_shift_r;
  logic [3:0] tx_bit_r;
  logic [7:0] tx_tim_r;
  logic txd_r;
  logic transmit_interrupt_r;
  wire tx_idle = tx_state_r == TX_IDLE;
  wire tx_bit_end = pre_tick && (tx_tim_r + BYTE_ONE >= bit_time_divider);
  // idle shifter takes the oldest held byte at once
  assign buf_out_ready = tx_idle;
  wire tx_load = buf_pop;

  always_comb
  begin
    tx_state_nxt = tx_state_r;
    case (tx_state_r)
      TX_IDLE:
        if (tx_load)
          tx_state_nxt = TX_START;
      TX_START:
        if (tx_bit_end)
          tx_state_nxt = TX_DATA;
      TX_DATA:
        if (tx_bit_end && tx_bit_r == LAST_DATA_BIT)
          tx_state_nxt = TX_STOP;
      TX_STOP:
        if (tx_bit_end)
          tx_state_nxt = TX_IDLE;
      default:
        tx_state_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      tx_state_r <= TX_IDLE;
      tx_shift_r <= BYTE_ZERO;
      tx_bit_r <= 4'h0;
      tx_tim_r <= BYTE_ZERO;
      txd_r <= 1'b1;
      transmit_interrupt_r <= 1'b0;
    end
    else
    begin
      tx_state_r <= tx_state_nxt;
      transmit_interrupt_r <= tx_load;
      if (tx_load)
      begin
        tx_shift_r <= buf_out_data;
        tx_bit_r <= 4'h0;
        tx_tim_r <= BYTE_ZERO;
      end
      else if (tx_bit_end)
        tx_tim_r <= BYTE_ZERO;
      else if (pre_tick)
        tx_tim_r <= tx_tim_r + BYTE_ONE;
      if (tx_state_r == TX_DATA && tx_bit_end)
      begin
        tx_shift_r <= {1'b0, tx_shift_r[7:1]};
        tx_bit_r <= tx_bit_r + 4'h1;
      end
      case (tx_state_nxt)
        TX_START: txd_r <= 1'b0;
        TX_DATA: txd_r <= (tx_state_r == TX_DATA && tx_bit_end) ? tx_shift_r[1] : tx_shift_r[0];
        default: txd_r <= 1'b1;
      endcase
    end
  end

  // receiver
  dsu_rx_state_t rx_state_r;
  logic [7:0] rx_shift_r;
  logic [3:0] rx_bit_r;
  logic [8:0] rx_tim_r;
  wire rx_fall = rxd_prev_r && !rxd_sync_r;
  // half a bit to mid start, then whole bits
  wire [8:0] rx_target = (rx_state_r == RX_START) ? {2'b00, bit_time_divider[7:1]}
                                                  : {1'b0, bit_time_divider};
  wire rx_sample = pre_tick && (rx_tim_r + 9'h001 >= rx_target);
  wire rx_done = rx_state_r == RX_STOP && rx_sample;

  logic [7:0] rx_hold_r;
  logic frame_err_r;
  logic overrun_r;
  logic rx_full_r;
  dsu_status_t line_status;
  logic receive_interrupt_r;

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      rx_state_r <= RX_IDLE;
      rx_shift_r <= BYTE_ZERO;
      rx_bit_r <= 4'h0;
      rx_tim_r <= 9'h000;
    end
    else
    begin
      if (rx_sample || (rx_state_r == RX_IDLE))
        rx_tim_r <= 9'h000;
      else if (pre_tick)
        rx_tim_r <= rx_tim_r + 9'h001;
      case (rx_state_r)
        RX_IDLE:
          if (rx_fall)
            rx_state_r <= RX_START;
        RX_START:
          if (rx_sample)
          begin
            rx_state_r <= rxd_sync_r ? RX_IDLE : RX_DATA;
            rx_bit_r <= 4'h0;
          end
        RX_DATA:
          if (rx_sample)
          begin
            rx_shift_r <= {rxd_sync_r, rx_shift_r[7:1]};
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == LAST_DATA_BIT)
              rx_state_r <= RX_STOP;
          end
        RX_STOP:
          if (rx_sample)
            rx_state_r <= RX_IDLE;
        default:
          rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // status and receive holding register
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      rx_hold_r <= BYTE_ZERO;
      frame_err_r <= 1'b0;
      overrun_r <= 1'b0;
      rx_full_r <= 1'b0;
      receive_interrupt_r <= 1'b0;
    end
    else
    begin
      receive_interrupt_r <= rx_done;
      if (rx_done)
      begin
        rx_hold_r <= rx_shift_r;
        frame_err_r <= !rxd_sync_r;
        overrun_r <= rx_full_r;
        rx_full_r <= 1'b1;
      end
      else if (data_rd)
        rx_full_r <= 1'b0;
    end
  end

  // status word: receive flags registered, transmit flags from state
  wire tx_full = buf_out_valid && !tx_idle;
  wire shifter_active = !tx_idle;
  assign line_status = {frame_err_r, overrun_r, rx_full_r, tx_full, shifter_active};

  // registered read data
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      BUS_RDATA <= 16'h0000;
    else if (BUS_RD)
    begin
      if (sel_status)
        BUS_RDATA <= {11'h000, line_status};
      else if (sel_low)
        BUS_RDATA <= {BYTE_ZERO, rx_hold_r};
      else if (sel_high)
        BUS_RDATA <= {rx_hold_r, BYTE_ZERO};
      else if (sel_div)
        BUS_RDATA <= div_r;
      else
        BUS_RDATA <= 16'h0000;
    end
  end

  assign TXD = txd_r;
  assign TRANSMIT_INTERRUPT_PULSE = transmit_interrupt_r;
  assign RECEIVE_INTERRUPT_PULSE = receive_interrupt_r;

  chk_idle_line_high: assert property (@(posedge REF_CLK) disable iff (RESET)
    tx_state_r == TX_IDLE && $past(tx_state_r) == TX_IDLE |-> TXD)
    else $error("line not high while idle");
  chk_start_bit_low: assert property (@(posedge REF_CLK) disable iff (RESET)
    tx_state_r == TX_START |-> !TXD)
    else $error("start bit not low");
  chk_frame_err_stop: assert property (@(posedge REF_CLK) disable iff (RESET)
    rx_done |=> frame_err_r == !$past(rxd_sync_r))
    else $error("framing flag wrong");
  chk_overrun_copy: assert property (@(posedge REF_CLK) disable iff (RESET)
    rx_done |=> overrun_r == $past(rx_full_r) && rx_full_r)
    else $error("overrun not copied");
  chk_rx_full_clear: assert property (@(posedge REF_CLK) disable iff (RESET)
    data_rd && !rx_done |=> !rx_full_r)
    else $error("receive full not cleared");
  chk_receive_interrupt_once: assert property (@(posedge REF_CLK) disable iff (RESET)
    rx_done |=> RECEIVE_INTERRUPT_PULSE ##1 !RECEIVE_INTERRUPT_PULSE)
    else $error("receive interrupt wrong");
  chk_idle_write_load: assert property (@(posedge REF_CLK) disable iff (RESET)
    data_wr && tx_idle && !buf_out_valid |-> ##2 (TRANSMIT_INTERRUPT_PULSE && shifter_active && !TXD))
    else $error("idle write did not start");
  chk_busy_write_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
    data_wr && !tx_idle && tx_state_nxt != TX_IDLE |=> tx_full)
    else $error("busy write not held");
  chk_stop_bit_high: assert property (@(posedge REF_CLK) disable iff (RESET)
    tx_state_r == TX_STOP |-> TXD)
    else $error("stop bit not high");
  chk_transmit_interrupt_start: assert property (@(posedge REF_CLK) disable iff (RESET)
    TRANSMIT_INTERRUPT_PULSE |-> shifter_active && !TXD)
    else $error("transmit interrupt without start");
  chk_rx_idle_wait: assert property (@(posedge REF_CLK) disable iff (RESET)
    rx_state_r == RX_IDLE && !rx_fall |=> rx_state_r == RX_IDLE)
    else $error("receiver left idle without edge");
  chk_low_read_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
    BUS_RD && sel_low |=> BUS_RDATA[15:8] == BYTE_ZERO)
    else $error("low data read upper byte not zero");
  chk_high_read_zero: assert property (@(posedge REF_CLK) disable iff (RESET)
    BUS_RD && sel_high |=> BUS_RDATA[7:0] == BYTE_ZERO)
    else $error("high data read lower byte not zero");
  chk_div_reset: assert property (@(posedge REF_CLK)
    $past(RESET) |-> div_r == BAUD_DIVIDER_RESET)
    else $error("divider not reset");

  cov_tx_frame: cover property (@(posedge REF_CLK) disable iff (RESET) tx_state_r == TX_STOP);
  cov_rx_byte: cover property (@(posedge REF_CLK) disable iff (RESET) rx_done);
  cov_overrun: cover property (@(posedge REF_CLK) disable iff (RESET) rx_done && rx_full_r);
  cov_held_byte: cover property (@(posedge REF_CLK) disable iff (RESET) tx_full);
  cov_frame_err: cover property (@(posedge REF_CLK) disable iff (RESET) rx_done && !rxd_sync_r);
endmodule // dsu_uart

// file: dv/dsu_term.sv
// serial terminal model: sends frames on rxd, collects frames seen on txd
// assumes the bus clock and a bit time of BT clocks
`timescale 1ns/1ps
module dsu_term #(parameter int BT = 12)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic txd,
  output logic rxd
);
  logic [8:0] got[$];
  logic [7:0] b;
  initial rxd = 1'b1;
  // one frame, stop level chosen by caller
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk) rxd <= f[i];
      repeat (BT - 1) @(negedge clk);
    end
    @(negedge clk) rxd <= 1'b1;
    repeat (2 * BT) @(negedge clk);
  endtask
  // mid-bit sampling of each outgoing frame
  initial
  begin
    @(negedge rst);
    forever
    begin
      @(negedge txd);
      // sample on the falling edge, away from the launching edge
      repeat (BT / 2) @(negedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BT) @(negedge clk);
        b[i] = txd;
      end
      repeat (BT) @(negedge clk);
      got.push_back({txd, b});
    end
  end
endmodule // dsu_term

// file: dv/tb_debug_serial_uart.sv
// self-checking bench for the debug serial port
// assumes dsu_uart with one-cycle bus strobes and the terminal model on its line
`timescale 1ns/1ps
module tb_debug_serial_uart
  import dsu_pkg::*;
;
  localparam int BT = 12;
  localparam logic [15:0] DIVV = 16'h0106;
  logic ref_clk, reset, bus_rd, bus_wr, rxd, txd, tx_irq, rx_irq;
  logic [15:0] bus_addr, bus_wdata, bus_rdata;
  logic [31:0] seed;
  logic [7:0] q[$];
  logic [7:0] b[4];
  int miscompares, checks_done, cycles, n_tx, n_rx;
  dsu_uart dut(.REF_CLK(ref_clk), .RESET(reset), .BUS_ADDR(bus_addr), .BUS_RD(bus_rd),
    .BUS_WR(bus_wr), .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata), .RXD(rxd),
    .TXD(txd), .TRANSMIT_INTERRUPT_PULSE(tx_irq), .RECEIVE_INTERRUPT_PULSE(rx_irq));
  dsu_term #(.BT(BT)) term(.clk(ref_clk), .rst(reset), .txd(txd), .rxd(rxd));
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] st(input logic fe, ov, rf, tf, act);
    return {11'h000, fe, ov, rf, tf, act};
  endfunction
  function automatic logic [15:0] dexp(input logic [7:0] d, input logic hi);
    return hi ? {d, 8'h00} : {8'h00, d};
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge ref_clk);
    bus_wr = 1'b0;
  endtask
  task automatic chkrd(input logic [15:0] a, input logic [15:0] exp);
    @(negedge ref_clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge ref_clk);
    bus_rd = 1'b0;
    cmp(bus_rdata, exp);
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 3000 && term.got.size() < n; i++)
      @(posedge ref_clk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(negedge ref_clk)
  begin
    cycles++;
    if (tx_irq === 1'b1)
      n_tx++;
    if (rx_irq === 1'b1)
      n_rx++;
    if (cycles == 6000)
    begin
      miscompares++;
      summarize();
    end
  end
  initial
  begin
    reset = 1'b1;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_addr = 16'h0000;
    bus_wdata = 16'h0000;
    seed = 32'hA0F03F70;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    cmp({15'h0000, txd}, 16'h0001);
    chkrd(ADDR_BAUD_DIVIDER, BAUD_DIVIDER_RESET);
    chkrd(ADDR_LINE_STATUS, st(0, 0, 0, 0, 0));
    chkrd(16'hC02C, 16'h0000);
    wr(ADDR_BAUD_DIVIDER, DIVV);
    chkrd(ADDR_BAUD_DIVIDER, DIVV);
    // byte pairs, odd rounds through the upper port
    for (int k = 0; k < 4; k++)
    begin
      for (int j = 0; j < 2; j++)
      begin
        seed = lfsr(seed);
        q.push_back(k[0] ? seed[15:8] : seed[7:0]);
        wr(k[0] ? ADDR_DATA_HIGH : ADDR_DATA_LOW, seed[15:0]);
        chkrd(ADDR_LINE_STATUS, st(0, 0, 0, j[0], 1));
      end
      wait_got(q.size() - 1);
      repeat (BT) @(negedge ref_clk);
      chkrd(ADDR_LINE_STATUS, st(0, 0, 0, 0, 1));
      wait_got(q.size());
      // let the stop bit finish before the next round
      repeat (BT) @(negedge ref_clk);
    end
    cmp(16'(term.got.size()), 16'(q.size()));
    foreach (q[i])
      cmp({7'h00, term.got[i]}, {7'h00, 1'b1, q[i]});
    chkrd(ADDR_LINE_STATUS, st(0, 0, 0, 0, 0));
    cmp({15'h0000, txd}, 16'h0001);
    cmp(n_tx[15:0], 16'h0008);
    b[0] = 8'h00;
    b[3] = 8'hFF;
    for (int i = 1; i < 3; i++)
    begin
      seed = lfsr(seed);
      b[i] = seed[7:0];
    end
    term.send(b[0], 1'b1);
    chkrd(ADDR_LINE_STATUS, st(0, 0, 1, 0, 0));
    chkrd(ADDR_DATA_LOW, dexp(b[0], 0));
    chkrd(ADDR_LINE_STATUS, st(0, 0, 0, 0, 0));
    term.send(b[1], 1'b1);
    term.send(b[2], 1'b1);
    chkrd(ADDR_LINE_STATUS, st(0, 1, 1, 0, 0));
    chkrd(ADDR_DATA_HIGH, dexp(b[2], 1));
    term.send(b[3], 1'b0);
    chkrd(ADDR_LINE_STATUS, st(1, 0, 1, 0, 0));
    term.send(b[1], 1'b1);
    chkrd(ADDR_LINE_STATUS, st(0, 1, 1, 0, 0));
    chkrd(ADDR_DATA_LOW, dexp(b[1], 0));
    cmp(n_rx[15:0], 16'h0005);
    summarize();
  end
endmodule // tb_debug_serial_uart
